//--- hdl/obt_top.sv
// Registered octal bus transceiver with capture log and AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "obt_map.svh"

// Capture log buffer, width and depth set by parameters
module obt_fifo
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
)
(
  input wire logic ref_clk, // System clock
  input wire logic arst_n, // Asynchronous reset
  input wire logic [WIDTH-1:0] in_data, // Word to store
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic out_valid, // Oldest word present
  input wire logic out_ready, // Oldest word taken
  output logic full // No room left
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign in_ready = !full;
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= '0;
    end
    else if (push)
    begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= '0;
    end
    else if (pop)
    begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule

// Function
// - Two eight-bit storage registers, A-to-B and B-to-A, each with its own capture clock and no load enable
// - Each capture clock rise loads its own bus, regardless of selects and enables
// - Source select low picks live bus data, high picks stored register data
// - Switching between live and stored data gives no glitch on the bus
// - Drive B while its enable is high; drive A while its enable is low
// - B enabled, B select low: bus B follows live bus A
// - B enabled, B select high: bus B shows the A-to-B register
// - A enabled, A select low: bus A follows live bus B
// - A enabled, A select high: bus A shows the B-to-A register
// - Both enabled, both selects high: both buses show stored data at once
// - Live A driven onto B: both captures store the A value
// - Live B driven onto A: both captures store the B value
// - Both live and both enabled: each driver reinforces its input, buses hold
// - Both drivers high-impedance from power-up until enables are asserted
module obt_top
  import obt_pkg::*;
#(
  parameter int LOG_DEPTH = 32,
  parameter int ADDR_W = 8
)
(
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [7:0] a_bus_in, // Bus A pin levels
  output logic [7:0] a_bus_out, // Bus A drive value
  output logic [7:0] a_bus_oe, // Bus A drive enables
  input wire logic [7:0] b_bus_in, // Bus B pin levels
  output logic [7:0] b_bus_out, // Bus B drive value
  output logic [7:0] b_bus_oe, // Bus B drive enables
  input wire logic b_port_drive_enable, // Drive bus B when high
  input wire logic a_port_drive_enable_n, // Drive bus A when low
  input wire logic a_side_capture_clock, // Rise stores bus A
  input wire logic b_side_capture_clock, // Rise stores bus B
  input wire logic b_output_source_select, // Bus B source, high = stored
  input wire logic a_output_source_select, // Bus A source, high = stored
  output logic log_ready, // Capture log can take a word
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  localparam int LOG_W = 18;

  // Capture path
  logic a_clk_prev_q;
  logic b_clk_prev_q;
  logic a_hit;
  logic b_hit;
  obt_byte_t a2b_q;
  obt_byte_t b2a_q;

  // Effective controls and output stage
  logic [`OBT_CTRL_W-1:0] ctrl_q;
  logic b_drive;
  logic a_drive;
  obt_src_t b_src;
  obt_src_t a_src;
  logic b_drive_q;
  logic a_drive_q;
  obt_byte_t b_out_q;
  obt_byte_t a_out_q;

  // Capture log
  logic [LOG_W-1:0] log_in;
  logic [LOG_W-1:0] log_head;
  logic log_valid;
  logic log_full;
  logic log_pop;
  logic ovf_q;

  // Bus slave
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_go;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;

  // Pins pass through synchronous; edge seen against last sample
  assign a_hit = a_side_capture_clock && !a_clk_prev_q;
  assign b_hit = b_side_capture_clock && !b_clk_prev_q;

  // Previous level starts high so a clock held high at reset is no edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_clk_prev_q <= 1'b1;
      b_clk_prev_q <= 1'b1;
    end
    else
    begin
      a_clk_prev_q <= a_side_capture_clock;
      b_clk_prev_q <= b_side_capture_clock;
    end
  end

  // Storage registers, deliberately without reset
  always_ff @(posedge ref_clk)
  begin
    if (a_hit)
    begin
      a2b_q <= a_bus_in;
    end
    if (b_hit)
    begin
      b2a_q <= b_bus_in;
    end
  end

  // Pin controls, or software values when override is set
  always_comb
  begin
    if (ctrl_q[`OBT_CTRL_OVR])
    begin
      b_drive = ctrl_q[`OBT_CTRL_BDRV];
      a_drive = !ctrl_q[`OBT_CTRL_ADRV_N];
      b_src = obt_src_t'(ctrl_q[`OBT_CTRL_BSEL]);
      a_src = obt_src_t'(ctrl_q[`OBT_CTRL_ASEL]);
    end
    else
    begin
      b_drive = b_port_drive_enable;
      a_drive = !a_port_drive_enable_n;
      b_src = obt_src_t'(b_output_source_select);
      a_src = obt_src_t'(a_output_source_select);
    end
  end

  // Enables reset low, so both buses float until asked to drive
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      b_drive_q <= 1'b0;
      a_drive_q <= 1'b0;
    end
    else
    begin
      b_drive_q <= b_drive;
      a_drive_q <= a_drive;
    end
  end

  // Whole byte is registered, so a select change cannot glitch the bus
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      b_out_q <= '0;
      a_out_q <= '0;
    end
    else
    begin
      unique case (b_src)
        OBT_SRC_LIVE: b_out_q <= a_bus_in;
        OBT_SRC_STORED: b_out_q <= a2b_q;
      endcase
      unique case (a_src)
        OBT_SRC_LIVE: a_out_q <= b_bus_in;
        OBT_SRC_STORED: a_out_q <= b2a_q;
      endcase
    end
  end

  // Same enable on all eight lanes
  assign b_bus_out = b_out_q;
  assign a_bus_out = a_out_q;
  assign b_bus_oe = {8{b_drive_q}};
  assign a_bus_oe = {8{a_drive_q}};

  // One log word per cycle with any capture; both bytes after the edge
  assign log_in = {b_hit, a_hit, (b_hit ? b_bus_in : b2a_q),
    (a_hit ? a_bus_in : a2b_q)};

  obt_fifo #(
    .WIDTH(LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_data(log_in),
    .in_valid(a_hit || b_hit),
    .in_ready(log_ready),
    .out_data(log_head),
    .out_valid(log_valid),
    .out_ready(log_pop),
    .full(log_full)
  );

  // Lost capture while full; a new loss beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_q <= 1'b0;
    end
    else if ((a_hit || b_hit) && !log_ready)
    begin
      ovf_q <= 1'b1;
    end
    else if (wr_go && wr_addr == `OBT_STAT_OFS && wr_strb[0] &&
      wr_data[`OBT_STAT_OVF])
    begin
      ovf_q <= 1'b0;
    end
  end

  // Write channels taken in either order, one write at a time
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  assign wr_go = !bvalid_q && (aw_held_q || s_axi_awvalid) &&
    (w_held_q || s_axi_wvalid);
  assign wr_hit = (wr_addr == `OBT_CTRL_OFS) || (wr_addr == `OBT_STAT_OFS);

  // Hold whichever half arrives first
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (wr_go)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `OBT_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `OBT_RESP_OKAY : `OBT_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register, all fields in the low byte
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `OBT_CTRL_RST;
    end
    else if (wr_go && wr_addr == `OBT_CTRL_OFS && wr_strb[0])
    begin
      ctrl_q <= wr_data[`OBT_CTRL_W-1:0];
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read side: one read at a time, answer one cycle after the address
  assign s_axi_arready = !rvalid_q;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign log_pop = rd_go && (s_axi_araddr == `OBT_LOG_OFS) && log_valid;

  // Read word selection; unmapped reads return zero
  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `OBT_CTRL_OFS: rd_word[`OBT_CTRL_W-1:0] = ctrl_q;
      `OBT_STAT_OFS:
      begin
        rd_word[`OBT_STAT_OVF] = ovf_q;
        rd_word[`OBT_STAT_LOG_NE] = log_valid;
        rd_word[`OBT_STAT_LOG_FULL] = log_full;
        rd_word[`OBT_STAT_BDRV] = b_drive_q;
        rd_word[`OBT_STAT_ADRV] = a_drive_q;
        rd_word[`OBT_STAT_BSEL] = b_src;
        rd_word[`OBT_STAT_ASEL] = a_src;
      end
      `OBT_HELD_OFS: rd_word[15:0] = {b2a_q, a2b_q};
      `OBT_LOG_OFS:
      begin
        rd_word[LOG_W-1:0] = log_valid ? log_head : '0;
        rd_word[`OBT_LOG_VALID] = log_valid;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data held until taken
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `OBT_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `OBT_RESP_OKAY : `OBT_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

//--- hdl/obt_map.svh
// Register offsets, field positions and reset values of the transceiver
`ifndef OBT_MAP_SVH
`define OBT_MAP_SVH

// Register byte offsets
`define OBT_CTRL_OFS 8'h00
`define OBT_STAT_OFS 8'h04
`define OBT_HELD_OFS 8'h08
`define OBT_LOG_OFS 8'h0c

// Control fields
`define OBT_CTRL_OVR 0
`define OBT_CTRL_BDRV 1
`define OBT_CTRL_ADRV_N 2
`define OBT_CTRL_BSEL 3
`define OBT_CTRL_ASEL 4
`define OBT_CTRL_W 5
`define OBT_CTRL_RST 5'h04

// Status fields
`define OBT_STAT_OVF 0
`define OBT_STAT_LOG_NE 1
`define OBT_STAT_LOG_FULL 2
`define OBT_STAT_BDRV 3
`define OBT_STAT_ADRV 4
`define OBT_STAT_BSEL 5
`define OBT_STAT_ASEL 6

// Capture log word layout and read flag
`define OBT_LOG_AHIT 16
`define OBT_LOG_BHIT 17
`define OBT_LOG_VALID 31

// Bus answers
`define OBT_RESP_OKAY 2'h0
`define OBT_RESP_SLVERR 2'h2

`endif

//--- hdl/obt_pkg.sv
// Types shared by the transceiver design
package obt_pkg;

  typedef logic [7:0] obt_byte_t;

  // Output source of one direction
  typedef enum logic {OBT_SRC_LIVE, OBT_SRC_STORED} obt_src_t;

endpackage

//--- test/obt_assertions.sv
// Pin and bus-answer assertions for the transceiver
`timescale 1ns/1ps
`default_nettype none
module obt_assertions
(
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [7:0] a_bus_in, b_bus_in, // Pin levels
  input wire logic [7:0] a_bus_out, b_bus_out, // Drive values
  input wire logic [7:0] a_bus_oe, b_bus_oe, // Drive enables
  input wire logic b_port_drive_enable, a_port_drive_enable_n, // Enables
  input wire logic a_side_capture_clock, b_side_capture_clock, // Captures
  input wire logic b_output_source_select, a_output_source_select, // Sels
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, // Write
  input wire logic s_axi_wready, s_axi_bvalid, // Write answer
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid // Read
);
  logic a_pv_q, b_pv_q, ab_ok_q, ba_ok_q, a_en, b_en;
  logic [7:0] ab_q, ba_q;
  assign b_en = arst_n & b_port_drive_enable;
  assign a_en = arst_n & ~a_port_drive_enable_n;
  // Prior samples reset high so a release never looks like a rise
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      a_pv_q <= 1'b1;
      b_pv_q <= 1'b1;
      ab_ok_q <= 1'b0;
      ba_ok_q <= 1'b0;
    end
    else
    begin
      a_pv_q <= a_side_capture_clock;
      b_pv_q <= b_side_capture_clock;
      ab_ok_q <= ab_ok_q | a_side_capture_clock & ~a_pv_q;
      ba_ok_q <= ba_ok_q | b_side_capture_clock & ~b_pv_q;
    end
  // Shadow bytes, unreset like the stored ones
  always_ff @(posedge ref_clk)
  begin
    if (a_side_capture_clock && !a_pv_q)
      ab_q <= a_bus_in;
    if (b_side_capture_clock && !b_pv_q)
      ba_q <= b_bus_in;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  pwr_hiz_a: assert property ($rose(arst_n) |-> !a_bus_oe && !b_bus_oe)
    else $error("driver on after reset");
  b_drive_a: assert property (b_bus_oe == {8{$past(b_en)}})
    else $error("bus B enable wrong");
  a_drive_a: assert property (a_bus_oe == {8{$past(a_en)}})
    else $error("bus A enable wrong");
  b_live_a: assert property (
    $past(b_en & ~b_output_source_select) |-> b_bus_out == $past(a_bus_in))
    else $error("bus B live wrong");
  a_live_a: assert property (
    $past(a_en & ~a_output_source_select) |-> a_bus_out == $past(b_bus_in))
    else $error("bus A live wrong");
  b_store_a: assert property (
    $past(b_en & b_output_source_select & ab_ok_q) |->
    b_bus_out == $past(ab_q))
    else $error("bus B stored wrong");
  a_store_a: assert property (
    $past(a_en & a_output_source_select & ba_ok_q) |->
    a_bus_out == $past(ba_q))
    else $error("bus A stored wrong");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  cover property (b_en && a_en && b_output_source_select &&
    a_output_source_select);
  cover property (a_side_capture_clock && b_side_capture_clock);
  cover property (s_axi_bvalid);
endmodule
bind obt_top obt_assertions u_obt_assertions (.*);
`default_nettype wire

//--- test/obt_bus_model.sv
// Far-side party and wire resolution for one eight-bit bus
`timescale 1ns/1ps
`default_nettype none
module obt_bus_model
(
  input wire logic ref_clk, // Clock for the floating pattern
  input wire logic [7:0] dev_out, // Device drive value
  input wire logic [7:0] dev_oe, // Device drive enables
  input wire logic [7:0] ext_out, // Far party drive value
  input wire logic ext_oe, // Far party drives
  output logic [7:0] bus // Resolved pin levels
);
  logic [7:0] flt_q;
  // Undriven lanes toggle each cycle so a stale value never passes
  always_ff @(posedge ref_clk)
    flt_q <= ~bus;
  // Clashing drivers give unknown; no keeper on an idle lane
  always_comb
    for (int i = 0; i < 8; i++)
      if (dev_oe[i] && ext_oe && dev_out[i] != ext_out[i])
        bus[i] = 1'bx;
      else if (dev_oe[i])
        bus[i] = dev_out[i];
      else if (ext_oe)
        bus[i] = ext_out[i];
      else
        bus[i] = flt_q[i];
endmodule
`default_nettype wire

//--- test/obt_top_tb.sv
// Self-checking bench for the registered octal bus transceiver
`timescale 1ns/1ps
`default_nettype none
`include "obt_map.svh"
module obt_top_tb
  import obt_pkg::*;
;
  localparam int DEPTH = 32;
  logic ref_clk = 1'b0, arst_n = 1'b0;
  logic b_port_drive_enable = 1'b0, a_port_drive_enable_n = 1'b1;
  logic a_side_capture_clock = 1'b0, b_side_capture_clock = 1'b0;
  logic b_output_source_select = 1'b0, a_output_source_select = 1'b0;
  obt_byte_t ext_a = 8'h00, ext_b = 8'h00;
  logic ext_a_oe = 1'b1, ext_b_oe = 1'b1;
  logic [7:0] a_bus_in, a_bus_out, a_bus_oe, b_bus_in, b_bus_out, b_bus_oe;
  logic log_ready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, s_axi_wdata = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  int error_cnt = 0, check_count = 0;
  obt_top #(.LOG_DEPTH(DEPTH)) u_obt_top (.*);
  obt_bus_model u_obt_bus_model_a (.ref_clk(ref_clk), .dev_out(a_bus_out),
    .dev_oe(a_bus_oe), .ext_out(ext_a), .ext_oe(ext_a_oe), .bus(a_bus_in));
  obt_bus_model u_obt_bus_model_b (.ref_clk(ref_clk), .dev_out(b_bus_out),
    .dev_oe(b_bus_oe), .ext_out(ext_b), .ext_oe(ext_b_oe), .bus(b_bus_in));
  always #50 ref_clk = ~ref_clk;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic guard(input int n);
    if (n >= 40)
    begin
      error_cnt++;
      $display("[FAIL] bus wait timed out");
      final_report();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 40);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    guard(n);
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 40);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(n);
  endtask
  // Capture clocks high then low for two cycles each
  task automatic pulse(input logic a, input logic b);
    @(posedge ref_clk);
    a_side_capture_clock <= a;
    b_side_capture_clock <= b;
    tick(2);
    a_side_capture_clock <= 1'b0;
    b_side_capture_clock <= 1'b0;
    tick(2);
  endtask
  // Far side lets go before the device drives, so buses never clash
  task automatic setup(input logic be, ae_n, bs, as, input obt_byte_t ea,
    input logic eao, input obt_byte_t eb, input logic ebo);
    @(posedge ref_clk);
    ext_a_oe <= ext_a_oe & eao;
    ext_b_oe <= ext_b_oe & ebo;
    tick(2);
    b_port_drive_enable <= be;
    a_port_drive_enable_n <= ae_n;
    b_output_source_select <= bs;
    a_output_source_select <= as;
    tick(2);
    ext_a <= ea;
    ext_b <= eb;
    ext_a_oe <= eao;
    ext_b_oe <= ebo;
    tick(3);
  endtask
  task automatic t_reset();
    check("a oe", a_bus_oe, 8'h00);
    check("b oe", b_bus_oe, 8'h00);
    axi_rd(`OBT_CTRL_OFS);
    check("ctrl", rd, `OBT_CTRL_RST);
    axi_rd(8'h40);
    check("unmapped", rsp, `OBT_RESP_SLVERR);
    axi_wr(`OBT_HELD_OFS, 32'h0);
    check("held wr", rsp, `OBT_RESP_SLVERR);
    $display("t_reset done");
  endtask
  // Software controls with the pins isolated; status shows what is in force
  task automatic t_ovr();
    axi_wr(`OBT_CTRL_OFS, 32'h1d);
    check("ctrl rsp", rsp, `OBT_RESP_OKAY);
    axi_rd(`OBT_CTRL_OFS);
    check("ctrl wr", rd, 32'h1d);
    axi_rd(`OBT_STAT_OFS);
    check("ovr sel", rd[6:3], 4'hc);
    axi_wr(`OBT_CTRL_OFS, 32'(`OBT_CTRL_RST));
    axi_rd(`OBT_STAT_OFS);
    check("pin sel", rd[6:3], 4'h0);
    $display("t_ovr done");
  endtask
  task automatic t_live();
    setup(1, 1, 0, 0, 8'h5a, 1, 8'h00, 0);
    check("b live", b_bus_in, 8'h5a);
    check("a off", a_bus_oe, 8'h00);
    setup(0, 0, 0, 0, 8'h00, 0, 8'hc3, 1);
    check("a live", a_bus_in, 8'hc3);
    check("b off", b_bus_oe, 8'h00);
    $display("t_live done");
  endtask
  task automatic t_store();
    setup(0, 1, 0, 0, 8'h3c, 1, 8'ha5, 1);
    pulse(1, 1);
    setup(0, 1, 1, 1, 8'h11, 1, 8'h22, 1);
    axi_rd(`OBT_HELD_OFS);
    check("held", rd[15:0], 16'ha53c);
    setup(1, 0, 1, 1, 8'h11, 0, 8'h22, 0);
    check("b stored", b_bus_in, 8'h3c);
    check("a stored", a_bus_in, 8'ha5);
    pulse(1, 0);
    tick(2);
    check("b recapt", b_bus_in, 8'ha5);
    $display("t_store done");
  endtask
  task automatic t_echo();
    setup(1, 1, 0, 0, 8'h77, 1, 8'h00, 0);
    pulse(1, 1);
    axi_rd(`OBT_HELD_OFS);
    check("echo a", rd[15:0], 16'h7777);
    setup(0, 0, 0, 0, 8'h00, 0, 8'h99, 1);
    pulse(1, 1);
    axi_rd(`OBT_HELD_OFS);
    check("echo b", rd[15:0], 16'h9999);
    setup(1, 0, 0, 0, 8'h00, 0, 8'h99, 1);
    setup(1, 0, 0, 0, 8'h00, 0, 8'h00, 0);
    tick(6);
    check("hold a", a_bus_in, 8'h99);
    check("hold b", b_bus_in, 8'h99);
    // Reset in mid-run while both ports drive: drivers must let go at once
    arst_n <= 1'b0;
    tick(2);
    check("rst a oe", a_bus_oe, 8'h00);
    check("rst b oe", b_bus_oe, 8'h00);
    arst_n <= 1'b1;
    tick(1);
    $display("t_echo done");
  endtask
  task automatic t_log();
    int n;
    n = 0;
    setup(0, 1, 0, 0, 8'h00, 1, 8'h00, 1);
    do
    begin
      axi_rd(`OBT_LOG_OFS);
      n++;
    end
    while (rd[31] && n < 40);
    for (int i = 0; i <= DEPTH; i++)
    begin
      check("room", log_ready, 1'(i < DEPTH));
      @(posedge ref_clk);
      ext_a <= 8'(i);
      pulse(1, 0);
    end
    axi_rd(`OBT_STAT_OFS);
    check("ovf full", rd[2:0], 3'h7);
    for (int i = 0; i <= DEPTH; i++)
    begin
      axi_rd(`OBT_LOG_OFS);
      check("log", {rd[31], rd[17:16], rd[7:0]},
        (i < DEPTH) ? {1'b1, 2'h1, 8'(i)} : 11'h000);
    end
    // Sticky loss flag clears on a one written to it
    axi_wr(`OBT_STAT_OFS, 32'h1);
    axi_rd(`OBT_STAT_OFS);
    check("ovf clr", rd[2:0], 3'h0);
    $display("t_log done");
  endtask
  initial
  begin
    tick(16);
    arst_n <= 1'b1;
    tick(1);
    t_reset();
    t_ovr();
    t_live();
    t_store();
    t_echo();
    t_log();
    final_report();
  end
endmodule
`default_nettype wire
